// >>> rtl/gpg_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the pin group.
  Assumes a 32-bit classic Wishbone bus, one register per aligned word.
*/
`ifndef GPG_DEFINES_SVH
`define GPG_DEFINES_SVH

// Register indices; byte address is four times the index
`define GPG_IX_MASK 6'h00
`define GPG_IX_MASK_SET 6'h01
`define GPG_IX_MASK_CLR 6'h02
`define GPG_IX_MASK_FLIP 6'h03
`define GPG_IX_LEVEL 6'h04
`define GPG_IX_LVL_SET 6'h05
`define GPG_IX_LVL_CLR 6'h06
`define GPG_IX_LVL_FLIP 6'h07
`define GPG_IX_SAMPLED 6'h08
`define GPG_IX_FLAGS 6'h09
`define GPG_IX_SETUP0 6'h10
`define GPG_IX_AL_MASK 6'h20
`define GPG_IX_AL_LEVEL 6'h21
`define GPG_IX_AL_SAMPLED 6'h22
`define GPG_IX_AL_FLAGS 6'h23

// Per-pin setup fields
`define GPG_SETUP_INV_BIT 7
`define GPG_SETUP_PULL_BIT 3
`define GPG_SETUP_SENSE_HI 2
`define GPG_SETUP_SENSE_LO 0
`define GPG_SETUP_RESET 8'h00

// Sense selection codes
`define GPG_SENSE_NONE 3'h0
`define GPG_SENSE_BOTH 3'h1
`define GPG_SENSE_RISE 3'h2
`define GPG_SENSE_FALL 3'h3
`define GPG_SENSE_BUF_OFF 3'h4
`define GPG_SENSE_LOW 3'h5

// Dead time after a pin interrupt, in peripheral clock cycles
`define GPG_DEAD_CYCLES 3

`endif

// >>> rtl/gpg_pkg.sv
/*
  Types shared by the pin group design.
  Assumes gpg_defines.svh is on the include path.
*/
`include "gpg_defines.svh"

package gpg_pkg;

  typedef logic [7:0] gpg_byte_t;

  typedef enum logic [2:0] {
    GPG_SENSE_NONE_E = `GPG_SENSE_NONE,
    GPG_SENSE_BOTH_E = `GPG_SENSE_BOTH,
    GPG_SENSE_RISE_E = `GPG_SENSE_RISE,
    GPG_SENSE_FALL_E = `GPG_SENSE_FALL,
    GPG_SENSE_OFF_E = `GPG_SENSE_BUF_OFF,
    GPG_SENSE_LOW_E = `GPG_SENSE_LOW
  } gpg_sense_t;

endpackage : gpg_pkg

// >>> rtl/gpg_pin_group.sv
/*
  General-purpose pin group: drive mask and level with set, clear and flip
  strobes, synchronised input readback, per-pin polarity, pull-up and sense
  setup, pin flags with interrupt, asynchronous level events and wake.
  Assumes a classic Wishbone master on clock and pin inputs that the pad
  ring presents as plain levels; pull-up and buffer enables go to the pads.
*/
// Register access over Wishbone was chosen for this implementation.
// Notes on behaviour
// RQ1 - Reset: drivers off, input buffers on
// RQ2 - Up to eight pins, bit n per pin
// RQ3 - Mask bit one drives level bit out
// RQ4 - Set strobe sets mask bits written one
// RQ5 - Clear strobe clears mask bits written one
// RQ6 - Flip strobe inverts mask bits written one
// RQ7 - Level set strobe sets level bits
// RQ8 - Level clear strobe clears level bits
// RQ9 - Level flip or sampled write inverts level
// RQ10 - Inputs synchronised, readable in any direction
// RQ11 - Setup for pin n at 0x10 plus n
// RQ12 - Polarity swap inverts input and output
// RQ13 - Polarity change gives internal edge seen
// RQ14 - Pull-up only when enabled and input
// RQ15 - Buffer off freezes synchroniser and sample
// RQ16 - Sense: both, rise, fall, low, none
// RQ17 - Asynchronous change sensing can request wake
// RQ18 - Fast aliases behave as regular registers
// RQ19 - Sense sets flag; request while enabled
// RQ20 - Level event follows pin, zero if off
// RQ21 - No new interrupt for three cycles
// RQ22 - Write one clears flag, set wins

`timescale 1ns/1ps

module gpg_pin_group
  import gpg_pkg::*;
#(
  parameter int PINS = 8,
  parameter int DEAD_CYC = `GPG_DEAD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic [PINS-1:0] padIn,
  output logic [PINS-1:0] padOut,
  output logic [PINS-1:0] padOeB,
  output logic [PINS-1:0] pullUpOn,
  output logic [PINS-1:0] inBufEn,
  output logic [PINS-1:0] pinEvent,
  output logic wakeReq,
  output logic irq
);

  localparam int DW = $clog2(DEAD_CYC + 1);
  localparam logic [DW-1:0] DEAD_LOAD = DW'(DEAD_CYC);

  // Bus state
  logic wbAck_q;
  logic [31:0] wbDatR_q;

  // Core registers
  logic [PINS-1:0] mask_q;
  logic [PINS-1:0] mask_d;
  logic [PINS-1:0] level_q;
  logic [PINS-1:0] level_d;
  logic [PINS-1:0] flags_q;
  logic [PINS-1:0] flags_d;

  // Output registers
  logic [PINS-1:0] padOut_q;
  logic [PINS-1:0] padOeB_q;
  logic [PINS-1:0] pullUpOn_q;
  logic [PINS-1:0] inBufEn_q;
  logic irq_q;

  // Per-pin views
  wire [PINS-1:0] invV;
  wire [PINS-1:0] pullV;
  wire [PINS-1:0] bufOnV;
  wire [PINS-1:0] senseEnV;
  wire [PINS-1:0] hitV;
  wire [PINS-1:0] sampledV;
  wire [PINS-1:0] changeV;
  wire [PINS-1:0] flagSetV;
  gpg_byte_t setupV [PINS];

  // Address decode
  wire req = wbCyc & wbStb;
  wire [5:0] rawIdx = wbAdr[7:2];

  // Fast aliases fold onto the regular indices
  wire [5:0] effIdx =
    (rawIdx == `GPG_IX_AL_MASK) ? `GPG_IX_MASK :
    (rawIdx == `GPG_IX_AL_LEVEL) ? `GPG_IX_LEVEL :
    (rawIdx == `GPG_IX_AL_SAMPLED) ? `GPG_IX_SAMPLED :
    (rawIdx == `GPG_IX_AL_FLAGS) ? `GPG_IX_FLAGS :
    rawIdx; // [RQ18]

  // Write takes effect on the edge where ack is seen high
  wire wrEn = req & wbAck_q & wbWe & wbSel[0];
  wire [PINS-1:0] wrBits = wbDatW[PINS-1:0];
  wire [7:0] wrByte = wbDatW[7:0];

  wire wrMask = wrEn & (effIdx == `GPG_IX_MASK);
  wire wrMaskSet = wrEn & (effIdx == `GPG_IX_MASK_SET);
  wire wrMaskClr = wrEn & (effIdx == `GPG_IX_MASK_CLR);
  wire wrMaskFlip = wrEn & (effIdx == `GPG_IX_MASK_FLIP);
  wire wrLevel = wrEn & (effIdx == `GPG_IX_LEVEL);
  wire wrLvlSet = wrEn & (effIdx == `GPG_IX_LVL_SET);
  wire wrLvlClr = wrEn & (effIdx == `GPG_IX_LVL_CLR);
  wire wrLvlFlip = wrEn & (effIdx == `GPG_IX_LVL_FLIP);
  wire wrSampled = wrEn & (effIdx == `GPG_IX_SAMPLED);
  wire wrFlags = wrEn & (effIdx == `GPG_IX_FLAGS);

  // Setup block: one byte-sized slot per pin
  wire [5:0] setupOff = effIdx - `GPG_IX_SETUP0;
  wire setupHit = (effIdx[5:3] == 3'h2) && (int'(setupOff[2:0]) < PINS); // [RQ11]
  wire wrSetup = wrEn & setupHit;

  // Mask strobes act only on bits written as one
  assign mask_d =
    wrMask ? wrBits :
    wrMaskSet ? (mask_q | wrBits) : // [RQ4]
    wrMaskClr ? (mask_q & ~wrBits) : // [RQ5]
    wrMaskFlip ? (mask_q ^ wrBits) : // [RQ6]
    mask_q;

  // Writing the sampled register flips the level, sample untouched
  assign level_d =
    wrLevel ? wrBits :
    wrLvlSet ? (level_q | wrBits) : // [RQ7]
    wrLvlClr ? (level_q & ~wrBits) : // [RQ8]
    (wrLvlFlip | wrSampled) ? (level_q ^ wrBits) : // [RQ9]
    level_q;

  // Clear by writing one; a set in the same cycle wins
  wire [PINS-1:0] flagClr = wrFlags ? wrBits : '0;
  assign flags_d = (flags_q & ~flagClr) | flagSetV; // [RQ22] [RQ19]

  // Read data
  wire [7:0] maskB = 8'(mask_q);
  wire [7:0] levelB = 8'(level_q);
  wire [7:0] sampB = 8'(sampledV);
  wire [7:0] flagsB = 8'(flags_q);
  wire [7:0] setupB = setupHit ? setupV[setupOff[2:0]] : 8'h00;
  // Strobe registers read back the register they act on
  wire selMask = (effIdx <= `GPG_IX_MASK_FLIP);
  wire selLevel = !selMask && (effIdx <= `GPG_IX_LVL_FLIP);
  wire selSamp = (effIdx == `GPG_IX_SAMPLED);
  wire selFlags = (effIdx == `GPG_IX_FLAGS);
  wire [7:0] rdByte =
    selMask ? maskB :
    selLevel ? levelB :
    selSamp ? sampB : // [RQ10]
    selFlags ? flagsB :
    setupB;
  wire [31:0] rdWord = {24'h000000, rdByte};

  // Request taken on the edge where ack is still low
  wire take = req & ~wbAck_q;

  // Bus slave: ack one cycle after the request, dropped the next
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wbAck_q <= 1'b0;
    end else begin
      wbAck_q <= take;
    end
  end

  // Read data latched with the request, zero on writes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wbDatR_q <= 32'h00000000;
    end else if (take) begin
      wbDatR_q <= wbWe ? 32'h00000000 : rdWord;
    end
  end

  // Drive-enable mask
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= '0; // [RQ1]
    end else begin
      mask_q <= mask_d;
    end
  end

  // Drive level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= '0;
    end else begin
      level_q <= level_d;
    end
  end

  // Pin flags
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Driven level, polarity applied at the pad
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      padOut_q <= '0;
    end else begin
      padOut_q <= level_q ^ invV; // [RQ3] [RQ12]
    end
  end

  // Driver enable, low while driving
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      padOeB_q <= '1; // [RQ1]
    end else begin
      padOeB_q <= ~mask_q; // [RQ3]
    end
  end

  // Pull-up follows the same mask so it never meets a driven pin
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pullUpOn_q <= '0;
    end else begin
      pullUpOn_q <= pullV & ~mask_q; // [RQ14]
    end
  end

  // Input buffer enables
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      inBufEn_q <= '1; // [RQ1]
    end else begin
      inBufEn_q <= bufOnV; // [RQ15]
    end
  end

  // Interrupt request, one cycle behind the flags
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & senseEnV); // [RQ19]
    end
  end

  // Per-pin setup, synchroniser and sensing
  for (genvar n = 0; n < PINS; n++) begin : gPin // [RQ2]
    gpg_byte_t setup_q;
    logic syncA_q;
    logic syncB_q;
    logic prev_q;
    logic [DW-1:0] dead_q;
    logic [DW-1:0] dead_d;
    logic hit;
    logic chg;
    gpg_sense_t sense;
    wire inv = setup_q[`GPG_SETUP_INV_BIT];
    wire bufOn = (sense != GPG_SENSE_OFF_E);
    // Inversion before the synchroniser so a polarity change is an edge
    wire pinIn = padIn[n] ^ inv; // [RQ12] [RQ13]
    wire rise = syncB_q & ~prev_q;
    wire fall = ~syncB_q & prev_q;
    wire setFlag = hit & (dead_q == '0); // [RQ21]

    assign sense = gpg_sense_t'(setup_q[`GPG_SETUP_SENSE_HI:`GPG_SETUP_SENSE_LO]);

    always_comb begin
      case (sense)
        GPG_SENSE_BOTH_E: hit = rise | fall; // [RQ16]
        GPG_SENSE_RISE_E: hit = rise;
        GPG_SENSE_FALL_E: hit = fall;
        GPG_SENSE_LOW_E: hit = ~syncB_q;
        default: hit = 1'b0;
      endcase
    end

    // Dead time counts down after each flag set
    always_comb begin
      if (setFlag) begin
        dead_d = DEAD_LOAD; // [RQ21]
      end else if (dead_q != '0) begin
        dead_d = dead_q - DW'(1);
      end else begin
        dead_d = dead_q;
      end
    end

    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        setup_q <= `GPG_SETUP_RESET;
      end else if (wrSetup && (setupOff[2:0] == 3'(n))) begin
        setup_q <= wrByte; // [RQ11]
      end
    end

    // Synchroniser frozen while the input buffer is off
    // Only the second stage and prev_q are read outside this block
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        syncA_q <= 1'b0;
        syncB_q <= 1'b0;
        prev_q <= 1'b0;
      end else if (bufOn) begin
        syncA_q <= pinIn; // [RQ10]
        syncB_q <= syncA_q;
        prev_q <= syncB_q;
      end // [RQ15]
    end

    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        dead_q <= '0;
      end else begin
        dead_q <= dead_d; // [RQ21]
      end
    end

    assign setupV[n] = setup_q;
    assign invV[n] = inv;
    assign pullV[n] = setup_q[`GPG_SETUP_PULL_BIT];
    assign bufOnV[n] = bufOn;
    assign hitV[n] = hit;
    assign flagSetV[n] = setFlag; // [RQ19]
    assign sampledV[n] = syncB_q;
    assign senseEnV[n] = (sense == GPG_SENSE_BOTH_E) |
                         (sense == GPG_SENSE_RISE_E) |
                         (sense == GPG_SENSE_FALL_E) |
                         (sense == GPG_SENSE_LOW_E);

    // Clockless change detect against the last sampled value
    always_comb begin
      case (sense)
        GPG_SENSE_BOTH_E: chg = pinIn ^ syncB_q; // [RQ17]
        GPG_SENSE_RISE_E: chg = pinIn & ~syncB_q;
        GPG_SENSE_FALL_E: chg = ~pinIn & syncB_q;
        GPG_SENSE_LOW_E: chg = ~pinIn;
        default: chg = 1'b0;
      endcase
    end

    assign changeV[n] = chg;

    // Level event must stay asynchronous to the clock
    assign pinEvent[n] = bufOn & pinIn; // [RQ20]
  end

  // Wake must work with the clock stopped, so the change path bypasses flip-flops; pending flags come from flags_q
  assign wakeReq = |(changeV | (flags_q & senseEnV)); // [RQ17]

  assign wbDatR = wbDatR_q;
  assign wbAck = wbAck_q;
  assign padOut = padOut_q;
  assign padOeB = padOeB_q;
  assign pullUpOn = pullUpOn_q;
  assign inBufEn = inBufEn_q;
  assign irq = irq_q;

endmodule : gpg_pin_group

// >>> sim/gpg_pin_group_monitor.sv
/*
  Port checker for the pin group.
  Assumes it is bound into every gpg_pin_group instance.
*/
`timescale 1ns/1ps
module gpg_pin_group_monitor #(
  parameter int PINS = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  input wire logic [PINS-1:0] padOut,
  input wire logic [PINS-1:0] padOeB,
  input wire logic [PINS-1:0] pullUpOn,
  input wire logic [PINS-1:0] inBufEn,
  input wire logic irq
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  chk_ack_answer: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("no ack");
  chk_ack_single: assert property (wbAck |=> !wbAck) else $error("long ack");
  chk_ack_cause: assert property (wbAck |-> $past(wbCyc && wbStb))
    else $error("stray ack");
  chk_reset_state: assert property ($rose(rst_b) |-> &padOeB && &inBufEn && !irq)
    else $error("bad reset state");
  chk_pull_output: assert property ((pullUpOn & ~padOeB) == '0)
    else $error("pull-up on output");
  chk_upper_zero: assert property (wbAck |-> wbDatR[31:8] == 24'h0)
    else $error("upper read bits set");
  // Pads move only after a register write
  chk_oe_cause: assert property ($changed(padOeB) |->
    $past(wbAck) || $past(wbAck, 2) || $past(wbAck, 3)) else $error("drive change unasked");
  chk_out_cause: assert property ($changed(padOut) |->
    $past(wbAck) || $past(wbAck, 2) || $past(wbAck, 3)) else $error("level change unasked");
endmodule : gpg_pin_group_monitor

bind gpg_pin_group gpg_pin_group_monitor #(.PINS(PINS)) gpg_pin_group_monitor_i (
  .clock(clock), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb), .wbDatR(wbDatR),
  .wbAck(wbAck), .padOut(padOut), .padOeB(padOeB), .pullUpOn(pullUpOn),
  .inBufEn(inBufEn), .irq(irq));

// >>> sim/gpg_pad_model.sv
/*
  Pin circuitry: driven pins read back, else a forced level, else pull-up.
  Assumes the bench drives extEn and extLvl; a bare pin flips each cycle.
*/
`timescale 1ns/1ps
module gpg_pad_model #(
  parameter int PINS = 8
) (
  input wire logic clock,
  input wire logic [PINS-1:0] padOut,
  input wire logic [PINS-1:0] padOeB,
  input wire logic [PINS-1:0] pullUpOn,
  input wire logic [PINS-1:0] extEn,
  input wire logic [PINS-1:0] extLvl,
  output logic [PINS-1:0] padIn
);
  logic [PINS-1:0] floatLvl_q = '0;
  always @(posedge clock) floatLvl_q <= ~floatLvl_q;
  always_comb begin
    for (int i = 0; i < PINS; i++)
      padIn[i] = !padOeB[i] ? padOut[i] : extEn[i] ? extLvl[i] : pullUpOn[i] | floatLvl_q[i];
  end
endmodule : gpg_pad_model

// >>> sim/testbench.sv
/*
  Self-checking bench for the pin group with a pad model.
  Assumes package, design, pad model and checker compile first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module testbench
  import gpg_pkg::*;
();
  logic clock = 1'h0, rst_b = 1'h0;
  logic wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0, wbDatR;
  logic wbAck, wakeReq, irq;
  gpg_byte_t padIn, padOut, padOeB, pullUpOn, inBufEn, pinEvent;
  gpg_byte_t extEn = 8'h00, extLvl = 8'h00;
  int num_errors = 0, n_tests = 0;
  gpg_sense_t codes[5] = '{GPG_SENSE_NONE_E, GPG_SENSE_BOTH_E, GPG_SENSE_RISE_E,
    GPG_SENSE_FALL_E, GPG_SENSE_LOW_E};
  always #50 clock = ~clock;
  gpg_pin_group gpg_pin_group_i (.clock(clock), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hF), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .padIn(padIn), .padOut(padOut), .padOeB(padOeB), .pullUpOn(pullUpOn), .inBufEn(inBufEn),
    .pinEvent(pinEvent), .wakeReq(wakeReq), .irq(irq));
  gpg_pad_model gpg_pad_model_i (.clock(clock), .padOut(padOut), .padOeB(padOeB),
    .pullUpOn(pullUpOn), .extEn(extEn), .extLvl(extLvl), .padIn(padIn));
  function automatic gpg_byte_t nxt(gpg_byte_t v, int k, gpg_byte_t d);
    case (k)
      0, 4: return d;
      1, 5: return v | d;
      2, 6: return v & ~d;
      default: return v ^ d;
    endcase
  endfunction : nxt
  // Reads compare against d
  task automatic bus(input logic we, input logic [5:0] ix, input gpg_byte_t d);
    int n;
    n = 0;
    {wbCyc, wbStb} <= 2'h3;
    wbWe <= we;
    wbAdr <= {ix, 2'h0};
    wbDatW <= {24'h0, d};
    do @(posedge clock); while (wbAck !== 1'h1 && n++ < 50);
    if (n >= 50) begin
      num_errors++;
      test_done();
    end
    if (!we) `CHK(wbDatR, {24'h0, d})
    {wbCyc, wbStb} <= 2'h0;
    @(posedge clock);
  endtask : bus
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin : watchdog
    #3000000;
    num_errors++;
    test_done();
  end
  initial begin : main
    gpg_byte_t m, l, e, s, d;
    int k;
    logic x;
    k = $urandom(32'h89448BB8);
    {m, l, e} = 24'h0;
    repeat (3) @(posedge clock);
    rst_b <= 1'h1;
    @(posedge clock);
    `CHK(padOeB & inBufEn, 8'hFF)
    $display("reset test done");
    repeat (40) begin
      k = $urandom_range(8, 0);
      d = 8'($urandom);
      bus(1'h1, 6'(k), d);
      m = (k < 4) ? nxt(m, k, d) : m;
      l = (k < 4) ? l : nxt(l, k, d);
      e = 8'($urandom);
      extEn <= ~m;
      extLvl <= e;
      repeat (4) @(posedge clock);
      `CHK({padOeB, padOut}, {~m, l})
      bus(1'h0, 6'h20, m);
      bus(1'h0, 6'h04, l);
      bus(1'h0, 6'h08, (m & l) | (~m & e));
    end
    $display("strobe test done");
    bus(1'h1, 6'h20, 8'hA5);
    m = 8'hA5;
    extEn <= ~m;
    s = ((m & l) | (~m & e)) ^ 8'h08;
    bus(1'h1, 6'h13, 8'h88);
    bus(1'h1, 6'h14, 8'h04);
    extLvl <= e ^ 8'h10;
    @(posedge clock);
    `CHK({pullUpOn[3], padOut[3], inBufEn[4]}, {1'h1, ~l[3], 1'h0})
    `CHK({pinEvent[4], pinEvent[1]}, {1'h0, e[1]})
    repeat (4) @(posedge clock);
    bus(1'h0, 6'h08, s);
    bus(1'h1, 6'h01, 8'h08);
    @(posedge clock);
    `CHK(pullUpOn[3], 1'h0)
    bus(1'h0, 6'h0A, 8'h00);
    $display("setup test done");
    foreach (codes[i]) begin
      e[1] = 1'h1;
      extLvl <= e;
      repeat (4) @(posedge clock);
      bus(1'h1, 6'h11, 8'(codes[i]));
      bus(1'h1, 6'h09, 8'hFF);
      e[1] = 1'h0;
      extLvl <= e;
      repeat (6) @(posedge clock);
      x = codes[i] inside {GPG_SENSE_BOTH_E, GPG_SENSE_FALL_E, GPG_SENSE_LOW_E};
      bus(1'h0, 6'h09, {6'h0, x, 1'h0});
      `CHK({irq, wakeReq}, {x, x})
      bus(1'h1, 6'h23, 8'h02);
      repeat (6) @(posedge clock);
      bus(1'h0, 6'h09, {6'h0, codes[i] == GPG_SENSE_LOW_E, 1'h0});
      bus(1'h1, 6'h11, 8'h00);
    end
    bus(1'h1, 6'h11, 8'h02);
    bus(1'h1, 6'h09, 8'hFF);
    bus(1'h1, 6'h11, 8'h82);
    repeat (6) @(posedge clock);
    bus(1'h0, 6'h09, 8'h02);
    $display("sense test done");
    test_done();
  end
endmodule : testbench
